// ==== wfc_defines.vh ====
// constants for the wake-frame clock and data recovery control block
`ifndef WFC_DEFINES_VH
`define WFC_DEFINES_VH

// register word addresses (7-bit)
`define WFC_ADDR_CTRL     7'h3e
`define WFC_ADDR_LIMIT    7'h3f

// reset values
`define WFC_CTRL_RESET    16'h0004
`define WFC_LIMIT_RESET   16'h9d8f

// control register field positions
`define WFC_EN_BIT        0
`define WFC_FILT_LO       2
`define WFC_FILT_HI       3
`define WFC_CLK_LO        5
`define WFC_CLK_HI        6

// limit register field positions
`define WFC_LIM_L_LO      0
`define WFC_LIM_L_HI      7
`define WFC_LIM_H_LO      8
`define WFC_LIM_H_HI      15

// filter select encodings
`define WFC_FILT_8        2'h0
`define WFC_FILT_16       2'h1
`define WFC_FILT_32       2'h2
`define WFC_FILT_ADAPT    2'h3

// filter time constants as shift amounts (8 = 2^3 ...)
`define WFC_SHIFT_8       3'h3
`define WFC_SHIFT_16      3'h4
`define WFC_SHIFT_32      3'h5

// adaptive spacing bounds, in bits
`define WFC_ADAPT_32_MIN  4'h2
`define WFC_ADAPT_32_MAX  4'h3
`define WFC_ADAPT_16_MAX  4'h8
`define WFC_ADAPT_8_MAX   4'ha

// bit-time estimate fraction width
`define WFC_FRAC_BITS     5

`endif

// ==== wfc_sample_div.v ====
// sampling-rate divider: one-cycle enable at clock / 1, 2, 4 or 8
`timescale 1ns/1ps
module wfc_sample_div (
    input  wire       clock,
    input  wire       reset,
    input  wire       run,
    input  wire [1:0] clk_sel,
    output reg        sample_en
);
    reg [2:0] count;
    reg [2:0] mask;

    // ratio is a power of two, so a masked counter wrap marks the pulse
    always @* begin
        case (clk_sel)
            2'h0:    mask = 3'h0;
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    // counter held at zero while idle so the first sample is prompt
    always @(posedge clock) begin
        if (reset || !run) begin
            count     <= 3'h0;
            sample_en <= 1'b0;
        end else begin
            count     <= count + 3'h1;
            sample_en <= ((count & mask) == 3'h0);
        end
    end
endmodule // wfc_sample_div

// ==== wfc_cdr_ctrl.v ====
// wake-frame clock and data recovery: control registers and bit-time tracker
`timescale 1ns/1ps
`include "wfc_defines.vh"
module wfc_cdr_ctrl (
    input  wire        clock,
    input  wire        reset,
    input  wire        restart,
    input  wire        reg_write,
    input  wire        reg_read,
    input  wire [6:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    input  wire        rx_pin,
    output reg  [7:0]  bit_time,
    output reg         bit_tick,
    output reg         recovery_active
);
    // control and limit storage
    reg        recovery_enable;
    reg [1:0]  clock_select;
    reg [1:0]  filter_constant_select;
    reg [7:0]  upper_bit_time_bound;
    reg [7:0]  lower_bit_time_bound;

    // receive synchroniser and edge tracking
    reg        rx_meta;
    reg        rx_sync;
    reg        rx_prev;

    // tracker state
    reg [7:0]  phase;
    reg [3:0]  bit_count;
    reg [12:0] est_fx;

    wire        sample_en;
    wire [7:0]  est_int = est_fx[12:`WFC_FRAC_BITS];
    wire [7:0]  est_half = {1'b0, est_int[7:1]};
    wire        fall = rx_prev & ~rx_sync;
    wire [8:0]  bound_sum = {1'b0, upper_bit_time_bound} + {1'b0, lower_bit_time_bound};

    // reset words held as parameters so their fields can be picked apart;
    // a bare literal cannot be part-selected
    localparam [15:0] ctrl_reset_word  = `WFC_CTRL_RESET;
    localparam [15:0] limit_reset_word = `WFC_LIMIT_RESET;

    // saturating step of the bit counter; long gaps pin it at its top
    // instead of wrapping back into the short-spacing band
    function [3:0] sat_inc;
        input [3:0] value;
        begin
            if (value != 4'hf)
                sat_inc = value + 4'h1;
            else
                sat_inc = value;
        end
    endfunction

    // time-constant shift from the filter code and spacing in bits
    function [2:0] tc_shift;
        input [1:0] sel;
        input [3:0] nbits;
        begin
            case (sel)
                `WFC_FILT_8:  tc_shift = `WFC_SHIFT_8;
                `WFC_FILT_16: tc_shift = `WFC_SHIFT_16;
                `WFC_FILT_32: tc_shift = `WFC_SHIFT_32;
                default: begin
                    // spacings outside 2..10 bits fall back to 16
                    if (nbits >= `WFC_ADAPT_32_MIN && nbits <= `WFC_ADAPT_32_MAX)
                        tc_shift = `WFC_SHIFT_32;
                    else if (nbits > `WFC_ADAPT_32_MAX && nbits <= `WFC_ADAPT_16_MAX)
                        tc_shift = `WFC_SHIFT_16;
                    else if (nbits > `WFC_ADAPT_16_MAX && nbits <= `WFC_ADAPT_8_MAX)
                        tc_shift = `WFC_SHIFT_8;
                    else
                        tc_shift = `WFC_SHIFT_16;
                end
            endcase
        end
    endfunction

    wfc_sample_div u_div (
        .clock     (clock),
        .reset     (reset),
        .run       (recovery_enable),
        .clk_sel   (clock_select),
        .sample_en (sample_en)
    );

    // register writes; restart drops the enable and discards any write in the same cycle
    always @(posedge clock) begin
        if (reset) begin
            recovery_enable        <= ctrl_reset_word[`WFC_EN_BIT];
            clock_select           <= ctrl_reset_word[`WFC_CLK_HI:`WFC_CLK_LO];
            filter_constant_select <= ctrl_reset_word[`WFC_FILT_HI:`WFC_FILT_LO];
            upper_bit_time_bound   <= limit_reset_word[`WFC_LIM_H_HI:`WFC_LIM_H_LO];
            lower_bit_time_bound   <= limit_reset_word[`WFC_LIM_L_HI:`WFC_LIM_L_LO];
        end else if (restart) begin
            recovery_enable <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == `WFC_ADDR_CTRL) begin
                // only the defined fields are stored
                recovery_enable        <= reg_wdata[`WFC_EN_BIT];
                clock_select           <= reg_wdata[`WFC_CLK_HI:`WFC_CLK_LO];
                filter_constant_select <= reg_wdata[`WFC_FILT_HI:`WFC_FILT_LO];
            end else if (reg_addr == `WFC_ADDR_LIMIT) begin
                upper_bit_time_bound <= reg_wdata[`WFC_LIM_H_HI:`WFC_LIM_H_LO];
                lower_bit_time_bound <= reg_wdata[`WFC_LIM_L_HI:`WFC_LIM_L_LO];
            end
        end
    end

    // registered read data; unmapped addresses read zero
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                `WFC_ADDR_CTRL:  reg_rdata <= {9'h000, clock_select, 1'b0,
                                    filter_constant_select, 1'b0, recovery_enable};
                `WFC_ADDR_LIMIT: reg_rdata <= {upper_bit_time_bound, lower_bit_time_bound};
                default:         reg_rdata <= 16'h0000;
            endcase
        end
    end

    // two flops before the pin reaches any logic
    always @(posedge clock) begin
        if (reset) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    // edge phase error and filtered, clamped estimate update
    reg                late;
    reg  [3:0]         nbits;
    reg  signed [9:0]  err;
    reg  signed [14:0] corr;
    reg  signed [14:0] sum;
    reg  signed [14:0] lo;
    reg  signed [14:0] hi;
    reg  [12:0]        next_est;
    always @* begin
        late  = (phase >= est_half);
        nbits = late ? sat_inc(bit_count) : bit_count;
        err   = late ? ($signed({2'b00, phase}) - $signed({2'b00, est_int}))
                     : $signed({2'b00, phase});
        // the estimate keeps 5 fraction bits, so 2^(5-shift) scales the error
        case (tc_shift(filter_constant_select, nbits))
            `WFC_SHIFT_8:  corr = {{5{err[9]}}, err} <<< 2;
            `WFC_SHIFT_16: corr = {{5{err[9]}}, err} <<< 1;
            default:       corr = {{5{err[9]}}, err};
        endcase
        sum = $signed({2'b00, est_fx}) + corr;
        lo  = $signed({2'b00, lower_bit_time_bound, {`WFC_FRAC_BITS{1'b0}}});
        hi  = $signed({2'b00, upper_bit_time_bound, {`WFC_FRAC_BITS{1'b0}}});
        // clamping at whole samples keeps a burst of noisy edges from dragging
        // the estimate outside the window that software set up
        if (sum < lo)
            next_est = lo[12:0];
        else if (sum > hi)
            next_est = hi[12:0];
        else
            next_est = sum[12:0];
    end

    // tracker: free-running bit phase, reseeded while disabled
    always @(posedge clock) begin
        if (reset || !recovery_enable) begin
            rx_prev   <= 1'b1;
            phase     <= 8'h00;
            bit_count <= 4'h0;
            est_fx    <= {bound_sum[8:1], {`WFC_FRAC_BITS{1'b0}}};
            bit_tick  <= 1'b0;
        end else begin
            bit_tick <= 1'b0;
            if (sample_en) begin
                rx_prev <= rx_sync;
                if (fall) begin
                    // a spacing under half a bit is noise and is not learned from
                    if (nbits != 4'h0)
                        est_fx <= next_est;
                    phase     <= 8'h00;
                    bit_count <= 4'h0;
                end else if (phase + 8'h01 >= est_int) begin
                    phase    <= 8'h00;
                    bit_tick <= 1'b1;
                    bit_count <= sat_inc(bit_count);
                end else begin
                    phase <= phase + 8'h01;
                end
            end
        end
    end

    // status outputs
    always @(posedge clock) begin
        if (reset) begin
            bit_time        <= 8'h00;
            recovery_active <= 1'b0;
        end else begin
            bit_time        <= est_int;
            recovery_active <= recovery_enable;
        end
    end
endmodule // wfc_cdr_ctrl

// ==== wfc_cdr_ctrl_properties.sv ====
// concurrent checks on the recovery control block ports
`timescale 1ns/1ps
module wfc_cdr_ctrl_properties (
    input wire        clock,
    input wire        reset,
    input wire        restart,
    input wire        reg_write,
    input wire        reg_read,
    input wire [6:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire        rx_pin,
    input wire [7:0]  bit_time,
    input wire        bit_tick,
    input wire        recovery_active
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // register port answers
    rsv_zero_a: assert property (reg_read && reg_addr == 7'h3e |=> (reg_rdata & 16'hff92) == 0)
        else $error("reserved control bits read nonzero");
    unmapped_zero_a: assert property (reg_read && reg_addr != 7'h3e && reg_addr != 7'h3f
        |=> reg_rdata == 16'h0000) else $error("unmapped read nonzero");
    rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    // no disable here: the clearing must show right after a reset edge
    reset_clear_a: assert property (disable iff (1'b0) reset
        |=> reg_rdata == 16'h0000 && !recovery_active && !bit_tick) else $error("reset outputs");
    enable_follow_a: assert property (reg_write && !restart && reg_addr == 7'h3e
        |=> ##1 recovery_active == $past(reg_wdata[0], 2)) else $error("active flag wrong");
    restart_clear_a: assert property (restart |=> ##1 !recovery_active)
        else $error("restart left recovery running");
    ctrl_readback_a: assert property (reg_write && !restart && reg_addr == 7'h3e
        ##1 !reg_write && !restart ##1 reg_read && reg_addr == 7'h3e
        |=> reg_rdata == ($past(reg_wdata, 3) & 16'h006d)) else $error("control readback");
    restart_keep_a: assert property (restart ##1 !reg_write
        ##1 reg_read && reg_addr == 7'h3e && !restart |=> !reg_rdata[0]) else $error("enable kept");
    // the tracker is held while disabled, so no bit boundary may be reported
    tick_quiet_a: assert property (!recovery_active [*3] |=> !bit_tick)
        else $error("tick while disabled");
endmodule // wfc_cdr_ctrl_properties

// ==== wfc_node_model.sv ====
// bus node model: recessive-high line with a falling edge every spacing clocks
`timescale 1ns/1ps
module wfc_node_model (
    input  wire        clock,
    input  wire        send,
    input  wire [15:0] spacing,
    output reg         rx_pin
);
    integer cnt = 0;
    initial rx_pin = 1'b1;
    // eight-clock dominant pulse opens each spacing; idle stays recessive
    always @(negedge clock) begin
        if (!send) begin
            rx_pin <= 1'b1;
            cnt <= 0;
        end else begin
            cnt <= (cnt + 1 >= spacing) ? 0 : cnt + 1;
            rx_pin <= (cnt >= 8);
        end
    end
endmodule // wfc_node_model

// ==== wfc_cdr_ctrl_tb_top.sv ====
// self-checking bench for the recovery control block
`timescale 1ns/1ps
module wfc_cdr_ctrl_tb_top;
    reg         clock = 1'b0;
    reg         reset = 1'b1;
    reg         restart = 1'b0;
    reg         reg_write = 1'b0;
    reg         reg_read = 1'b0;
    reg  [6:0]  reg_addr = 7'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         send = 1'b0;
    reg  [15:0] spacing = 16'h0060;
    wire [15:0] reg_rdata;
    wire [7:0]  bit_time;
    wire        bit_tick;
    wire        recovery_active;
    wire        rx_pin;
    integer     fail_count = 0;
    integer     n_checks = 0;
    integer     i;
    integer     gap;
    always #12.5 clock = ~clock;
    wfc_cdr_ctrl DUT (.clock(clock), .reset(reset), .restart(restart), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_pin(rx_pin), .bit_time(bit_time), .bit_tick(bit_tick),
        .recovery_active(recovery_active));
    wfc_node_model node (.clock(clock), .send(send), .spacing(spacing), .rx_pin(rx_pin));
    // comparison tasks count every check
    task cmp16(input string what, input [15:0] exp, input [15:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cmp8(input string what, input [7:0] exp, input [7:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle strobes, driven on the falling edge
    task wr(input [6:0] a, input [15:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
    endtask
    task rd(input [6:0] a, input [15:0] exp);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_read = 1'b0;
        cmp16("register", exp, reg_rdata);
    endtask
    // cycles from one bit boundary pulse to the next, both waits bounded;
    // two cycles are skipped so a pulse timed by the old rate is not used
    task tick_gap(output integer gap);
        integer k;
        begin
            gap = 0;
            repeat (2) @(negedge clock);
            for (k = 0; k < 4000 && bit_tick !== 1'b1; k = k + 1)
                @(negedge clock);
            @(negedge clock);
            gap = 1;
            while (bit_tick !== 1'b1 && gap < 4000) begin
                @(negedge clock);
                gap = gap + 1;
            end
        end
    endtask
    // one learned edge from the reseeded estimate: the first fall comes within
    // half a bit of enabling and is not learned, the second comes gap clocks later
    task one_edge(input [15:0] ctrl, input [15:0] gap, input [7:0] exp);
        spacing = gap;
        wr(7'h3e, ctrl);
        send = 1'b1;
        repeat (gap + 16'h0064) @(negedge clock);
        cmp8("learned bit time", exp, bit_time);
        send = 1'b0;
        wr(7'h3e, 16'h0004);
        repeat (4) @(negedge clock);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge clock);
        fail_count = fail_count + 1;
        conclude;
    end
    initial begin
        repeat (20) @(negedge clock);
        reset = 1'b0;
        rd(7'h3e, 16'h0004);
        rd(7'h3f, 16'h9d8f);
        rd(7'h20, 16'h0000);
        wr(7'h3e, 16'hffff);
        rd(7'h3e, 16'h006d);
        for (i = 0; i < 16; i = i + 1) begin
            wr(7'h3e, {9'h000, i[3:2], 1'b0, i[1:0], 2'b00});
            rd(7'h3e, {9'h000, i[3:2], 1'b0, i[1:0], 2'b00});
        end
        $display("test registers done");
        wr(7'h3e, 16'h0069);
        @(negedge clock);
        cmp8("active", 8'h01, {7'h00, recovery_active});
        restart = 1'b1;
        @(negedge clock);
        restart = 1'b0;
        rd(7'h3e, 16'h0068);
        cmp8("active", 8'h00, {7'h00, recovery_active});
        cmp8("bit time", 8'h96, bit_time);
        $display("test restart done");
        // fastest clock with the default limit pair, the usable setting at top speed
        wr(7'h3e, 16'h0005);
        send = 1'b1;
        repeat (4000) @(negedge clock);
        cmp8("bit time", 8'h8f, bit_time);
        spacing = 16'h00c0;
        repeat (8000) @(negedge clock);
        cmp8("bit time", 8'h9d, bit_time);
        send = 1'b0;
        wr(7'h3e, 16'h0004);
        repeat (4) @(negedge clock);
        cmp8("active", 8'h00, {7'h00, recovery_active});
        cmp8("bit time", 8'h96, bit_time);
        $display("test tracking done");
        // from 150 samples: one spacing of a bit and 41 samples, then 2, 4 and 9 bits
        one_edge(16'h0001, 16'h00c0, 8'h9b);
        one_edge(16'h0005, 16'h00c0, 8'h98);
        one_edge(16'h0009, 16'h00c0, 8'h97);
        one_edge(16'h000d, 16'h0150, 8'h97);
        one_edge(16'h000d, 16'h0280, 8'h98);
        one_edge(16'h000d, 16'h056f, 8'h9b);
        $display("test filter constants done");
        // idle line: a boundary every 150 samples, at clock / 2 and clock / 8
        wr(7'h3e, 16'h0025);
        tick_gap(gap);
        cmp16("tick gap", 16'h012c, gap[15:0]);
        wr(7'h3e, 16'h0065);
        tick_gap(gap);
        cmp16("tick gap", 16'h04b0, gap[15:0]);
        wr(7'h3e, 16'h0004);
        $display("test sampling rates done");
        conclude;
    end
endmodule // wfc_cdr_ctrl_tb_top

bind wfc_cdr_ctrl wfc_cdr_ctrl_properties chk (.clock(clock), .reset(reset), .restart(restart),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .bit_time(bit_time), .bit_tick(bit_tick),
    .recovery_active(recovery_active));
